/* File: hdl/pfo_top.sv */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pfo_defs.svh"
// Overview of operation
// - Per-fault interrupt enable gates CPU interrupt request
// - Faults always disable mapped outputs, regardless
// - Per-fault mode bit: 1 automatic, 0 manual
// - Read-only bit shows present fault pin level
// - Event flag set within two cycles of rise
// - Writing one to acknowledge clears that flag
// - Acknowledge bits read zero; writing zero ignored
// - Six sense samples taken just before dead-time ends
// - Override feeds manual bits into output stage
// - Override never stops or resets the counter
// - Clearing override returns generator outputs at once
// - Manual pairing differs for complementary and independent
// - One counter tick per bus clock, no prescaler
// - Center-aligned cycle lasts twice the modulus
// - Edge-aligned cycle lasts one modulus
// - Parameters reload every 2^code cycles, code 01 two
// - Write-once eight-bit map selects outputs faults disable
// - Disabled module floats pins unless override set
module pfo_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] FAULT_IN,
  input wire logic [2:0] SENSE_IN,
  output pfo_pkg::pfo_ch_t PWM_OUT,
  output pfo_pkg::pfo_ch_t PWM_OE_N,
  output logic IRQ
);
  import pfo_pkg::*;

  // Known register offsets; anything else answers with an error
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `PFO_ADDR_FCR) || (a == `PFO_ADDR_FSR) || (a == `PFO_ADDR_ACK) ||
              (a == `PFO_ADDR_OVR) || (a == `PFO_ADDR_CFG) || (a == `PFO_ADDR_MAP) ||
              (a == `PFO_ADDR_MOD) || (a == `PFO_ADDR_DUTY);
  endfunction : reg_hit

  // Reload mask: code n reloads every 2^n cycles
  function automatic logic [2:0] ld_mask(input logic [1:0] code);
    case (code)
      2'h0: ld_mask = 3'h0;
      2'h1: ld_mask = 3'h1;
      2'h2: ld_mask = 3'h3;
      default: ld_mask = 3'h7;
    endcase
  endfunction : ld_mask

  logic [3:0] flt_s1_q, flt_s2_q, flt_s3_q;
  logic [2:0] sns_s1_q, sns_s2_q;
  logic [3:0] flt_rise, ack_hit, flag_q, fdis_q, int_en, auto_sel;
  logic [7:0] fcr_q, map_q;
  logic map_done_q;
  logic [6:0] ovr_q;
  logic [4:0] cfg_q;
  pfo_cnt_t mod_q, duty_q, mod_act_q, duty_act_q, cnt_q;
  logic [1:0] ldfq_act_q;
  logic [2:0] ld_cnt_q;
  pfo_dir_e dir_q;
  logic [31:0] rdata;
  logic [31:0] prdata_q;
  logic setup, wr_en, gen_en, ovr_en, indep, center, boundary, gen_raw;
  pfo_ch_t gen_req, man_req, stage_req, stage_out, dt_smp, blocked;
  pfo_ch_t pwm_q, oe_n_q;

  // Pins cross into the clock domain through two flops before use
  always_ff @(posedge CLK) begin
    if (RST) begin
      flt_s1_q <= 4'h0;
      flt_s2_q <= 4'h0;
      flt_s3_q <= 4'h0;
      sns_s1_q <= 3'h0;
      sns_s2_q <= 3'h0;
    end else begin
      flt_s1_q <= FAULT_IN;
      flt_s2_q <= flt_s1_q;
      flt_s3_q <= flt_s2_q;
      sns_s1_q <= SENSE_IN;
      sns_s2_q <= sns_s1_q;
    end
  end

  // APB: zero-wait access, read data captured in the setup cycle
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & reg_hit(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~reg_hit(PADDR);
  assign PRDATA = prdata_q;

  assign gen_en = cfg_q[`PFO_CFG_EN_BIT];
  assign indep = cfg_q[`PFO_CFG_INDEP_BIT];
  assign center = cfg_q[`PFO_CFG_CENTER_BIT];
  assign ovr_en = ovr_q[`PFO_OVR_EN_BIT];

  // Read mux; acknowledge bits always read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR)
      `PFO_ADDR_FCR: rdata[7:0] = fcr_q;
      `PFO_ADDR_FSR: begin
        for (int i = 0; i < 4; i++) begin
          rdata[2*i+1] = flt_s2_q[i];
          rdata[2*i] = flag_q[i] | flt_rise[i];
        end
      end
      `PFO_ADDR_ACK: rdata[`PFO_ACK_DT_LSB +: 6] = dt_smp;
      `PFO_ADDR_OVR: rdata[6:0] = ovr_q;
      `PFO_ADDR_CFG: rdata[4:0] = cfg_q;
      `PFO_ADDR_MAP: rdata[7:0] = map_q;
      `PFO_ADDR_MOD: rdata[15:0] = mod_q;
      `PFO_ADDR_DUTY: rdata[15:0] = duty_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      prdata_q <= rdata;
    end
  end

  // Control registers; FCR, OVR and CFG cleared on reset, MOD and DUTY loaded with their reset values
  always_ff @(posedge CLK) begin
    if (RST) begin
      fcr_q <= 8'h00;
      ovr_q <= 7'h00;
      cfg_q <= 5'h00;
      mod_q <= `PFO_MOD_RST;
      duty_q <= `PFO_DUTY_RST;
    end else if (wr_en) begin
      case (PADDR)
        `PFO_ADDR_FCR: fcr_q <= PWDATA[7:0];
        `PFO_ADDR_OVR: ovr_q <= PWDATA[6:0];
        `PFO_ADDR_CFG: cfg_q <= PWDATA[4:0];
        `PFO_ADDR_MOD: mod_q <= PWDATA[15:0];
        `PFO_ADDR_DUTY: duty_q <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Disable map takes only its first write until reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      map_q <= `PFO_MAP_RST;
      map_done_q <= 1'b0;
    end else if (wr_en && PADDR == `PFO_ADDR_MAP && !map_done_q) begin
      map_q <= PWDATA[7:0];
      map_done_q <= 1'b1;
    end
  end

  // Per-fault event flag and output-disable latch
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flt
      assign int_en[g] = fcr_q[2*g+1];
      assign auto_sel[g] = fcr_q[2*g];
      assign flt_rise[g] = flt_s2_q[g] & ~flt_s3_q[g];
      assign ack_hit[g] = wr_en && PADDR == `PFO_ADDR_ACK && PWDATA[g];

      // A rise in the acknowledge cycle keeps the flag set
      always_ff @(posedge CLK) begin
        if (RST) begin
          flag_q[g] <= 1'b0;
        end else if (flt_rise[g]) begin
          flag_q[g] <= 1'b1;
        end else if (ack_hit[g]) begin
          flag_q[g] <= 1'b0;
        end
      end

      // Pin high disables outputs whatever the interrupt enable says
      always_ff @(posedge CLK) begin
        if (RST) begin
          fdis_q[g] <= 1'b0;
        end else if (flt_s2_q[g]) begin
          fdis_q[g] <= 1'b1;
        end else if (auto_sel[g] ? boundary : !flag_q[g]) begin
          fdis_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign IRQ = |(flag_q & int_en);

  // Counter keeps running under override; only the enable stops it
  always_ff @(posedge CLK) begin
    if (RST || !gen_en) begin
      cnt_q <= 16'h0000;
      dir_q <= PFO_UP;
    end else if (!center) begin
      cnt_q <= boundary ? 16'h0000 : cnt_q + 16'h0001;
    end else begin
      case (dir_q)
        PFO_UP: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q + 16'h0001 >= mod_act_q) begin
            dir_q <= PFO_DOWN;
          end
        end
        PFO_DOWN: begin
          cnt_q <= cnt_q - 16'h0001;
          if (boundary) begin
            dir_q <= PFO_UP;
          end
        end
        default: dir_q <= PFO_UP;
      endcase
    end
  end

  // One tick per clock, so the cycle end is a plain compare
  assign boundary = gen_en && (center ? (dir_q == PFO_DOWN && cnt_q <= 16'h0001)
                                      : (cnt_q + 16'h0001 >= mod_act_q));

  // Buffered values take effect on a reload boundary, or every cycle while the generator is disabled
  always_ff @(posedge CLK) begin
    if (RST) begin
      mod_act_q <= `PFO_MOD_RST;
      duty_act_q <= `PFO_DUTY_RST;
      ldfq_act_q <= 2'h0;
      ld_cnt_q <= 3'h0;
    end else if (!gen_en || (boundary && ld_cnt_q == ld_mask(ldfq_act_q))) begin
      mod_act_q <= mod_q;
      duty_act_q <= duty_q;
      ldfq_act_q <= cfg_q[`PFO_CFG_LDFQ_LSB +: 2];
      ld_cnt_q <= 3'h0;
    end else if (boundary) begin
      ld_cnt_q <= ld_cnt_q + 3'h1;
    end
  end

  // Generator and manual requests; override switch is combinational
  assign gen_raw = gen_en && (cnt_q < duty_act_q);
  generate
    for (g = 0; g < 3; g++) begin : g_req
      assign gen_req[2*g] = gen_raw;
      assign gen_req[2*g+1] = gen_en && (indep ? gen_raw : !gen_raw);
      assign man_req[2*g] = ovr_q[2*g];
      assign man_req[2*g+1] = ovr_q[2*g+1] & (indep | ~ovr_q[2*g]);
    end
  endgenerate
  assign stage_req = ovr_en ? man_req : gen_req;

  // Three dead-time stages, one per output pair
  pfo_pair_if pair_if [3] ();
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      assign pair_if[g].cmpl = ~indep;
      assign pair_if[g].req = stage_req[2*g +: 2];
      assign pair_if[g].sense = sns_s2_q[g];
      assign stage_out[2*g +: 2] = pair_if[g].out;
      assign dt_smp[2*g +: 2] = pair_if[g].smp;
      pfo_pair_stage u_stage (
        .clk(CLK),
        .rst(RST),
        .pr(pair_if[g])
      );
    end
  endgenerate

  // Any latched fault forces the mapped outputs inactive
  assign blocked = map_q[5:0] & {6{|fdis_q}};

  // Pins float while disabled, except under manual override
  always_ff @(posedge CLK) begin
    if (RST) begin
      pwm_q <= 6'h00;
      oe_n_q <= 6'h3f;
    end else begin
      pwm_q <= stage_out & ~blocked;
      oe_n_q <= (gen_en || ovr_en) ? 6'h00 : 6'h3f;
    end
  end
  assign PWM_OUT = pwm_q;
  assign PWM_OE_N = oe_n_q;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_irq_gate: assert property (flt_rise[0] && int_en[0] && !wr_en |=> IRQ)
    else $error("enabled fault event raised no interrupt");
  chk_fault_blocks: assert property (|fdis_q |=> (pwm_q & map_q[5:0]) == 6'h00)
    else $error("mapped output active during fault");
  chk_flag_timing: assert property ($rose(flt_s1_q[0]) |-> ##2 flag_q[0])
    else $error("fault flag late after pin rise");
  chk_ack_clear: assert property (ack_hit[1] && !flt_rise[1] |=> !flag_q[1])
    else $error("acknowledge did not clear flag");
  chk_ack_zero: assert property (wr_en && PADDR == `PFO_ADDR_ACK && PWDATA[3:0] == 4'h0
    |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("zero acknowledge changed a flag");
  chk_override_src: assert property (ovr_en && indep ##1 !(|fdis_q)
    |=> PWM_OUT == $past(ovr_q[5:0], 2))
    else $error("override not feeding manual bits");
  chk_counter_runs: assert property (ovr_en && gen_en && !center && !boundary
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter stalled under override");
  chk_release_now: assert property ($fell(ovr_en) && indep ##1 !(|fdis_q)
    |=> PWM_OUT == {6{$past(gen_raw, 2)}})
    else $error("generator not restored on override release");
  chk_float_off: assert property (!gen_en && !ovr_en |=> PWM_OE_N == 6'h3f)
    else $error("pins driven while disabled");
  chk_edge_wrap: assert property (gen_en && !center && boundary && $stable(gen_en)
    |=> cnt_q == 16'h0000)
    else $error("edge counter did not wrap");

  // Latch release, write-once map, reload timing and status read path
  chk_map_once: assert property (map_done_q && wr_en && PADDR == `PFO_ADDR_MAP
    |=> map_q == $past(map_q))
    else $error("disable map rewritten after first write");
  chk_manual_hold: assert property (fdis_q[1] && !auto_sel[1] && flag_q[1]
    |=> fdis_q[1])
    else $error("manual fault released before acknowledge");
  chk_auto_release: assert property (fdis_q[0] && auto_sel[0] && !flt_s2_q[0]
    && boundary |=> !fdis_q[0])
    else $error("automatic fault not released at boundary");
  chk_reload_hold: assert property (gen_en && !boundary
    |=> mod_act_q == $past(mod_act_q))
    else $error("modulus reloaded off a cycle boundary");
  chk_pin_level: assert property (setup && !PWRITE && PADDR == `PFO_ADDR_FSR
    |=> PRDATA[1] == $past(flt_s2_q[0]))
    else $error("status read does not show pin level");
  chk_manual_pair: assert property (ovr_en && !indep
    |-> !(stage_req[0] && stage_req[1]) && stage_req[0] == ovr_q[0])
    else $error("complementary manual pair both requested");

  cov_fault_ack: cover property (flt_rise[0] ##[1:20] ack_hit[0]);
  cov_override: cover property (ovr_en && gen_en ##1 !ovr_en);
  cov_center_cycle: cover property (center && boundary);
  cov_sense_hit: cover property ($rose(dt_smp[0]));
  cov_auto_release: cover property (auto_sel[0] && $fell(fdis_q[0]));
endmodule : pfo_top

/* File: hdl/pfo_defs.svh */
`ifndef PFO_DEFS_SVH
`define PFO_DEFS_SVH

// Register byte offsets on the APB slave
`define PFO_ADDR_FCR 8'h00
`define PFO_ADDR_FSR 8'h04
`define PFO_ADDR_ACK 8'h08
`define PFO_ADDR_OVR 8'h0c
`define PFO_ADDR_CFG 8'h10
`define PFO_ADDR_MAP 8'h14
`define PFO_ADDR_MOD 8'h18
`define PFO_ADDR_DUTY 8'h1c

// Field positions
`define PFO_ACK_DT_LSB 4
`define PFO_OVR_EN_BIT 6
`define PFO_CFG_EN_BIT 0
`define PFO_CFG_INDEP_BIT 1
`define PFO_CFG_LDFQ_LSB 2
`define PFO_CFG_CENTER_BIT 4

// Reset values
`define PFO_MAP_RST 8'hff
`define PFO_MOD_RST 16'h0100
`define PFO_DUTY_RST 16'h0080

// Timing: dead time in ns, clock period in ps, least time rounds up
`define PFO_DEAD_NS 100
`define PFO_CLK_PS 5000
`define PFO_DEAD_CYC ((`PFO_DEAD_NS * 1000 + `PFO_CLK_PS - 1) / `PFO_CLK_PS)

`endif

/* File: hdl/pfo_pkg.sv */
package pfo_pkg;
  typedef logic [15:0] pfo_cnt_t;
  typedef logic [7:0] pfo_dt_t;
  typedef logic [5:0] pfo_ch_t;
  typedef enum logic {PFO_UP, PFO_DOWN} pfo_dir_e;
endpackage : pfo_pkg

/* File: hdl/pfo_pair_if.sv */
`timescale 1ns/1ps
// One complementary pair between the control logic and its output stage
interface pfo_pair_if;
  logic cmpl;
  logic [1:0] req;
  logic sense;
  logic [1:0] out;
  logic [1:0] smp;
  modport ctrl (output cmpl, output req, output sense, input out, input smp);
  modport stage (input cmpl, input req, input sense, output out, output smp);
endinterface : pfo_pair_if

/* File: hdl/pfo_pair_stage.sv */
`timescale 1ns/1ps
`include "pfo_defs.svh"
// Dead-time stage for one output pair, with current-sense capture
module pfo_pair_stage (
  input wire logic clk,
  input wire logic rst,
  pfo_pair_if.stage pr
);
  import pfo_pkg::*;

  logic [1:0] out_q;
  logic [1:0] smp_q;
  pfo_dt_t cnt_q [2];
  pfo_dt_t lim;

  // Independent mode needs no gap between the pair
  assign lim = pr.cmpl ? pfo_dt_t'(`PFO_DEAD_CYC) : 8'h00;

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_ch
      logic partner_on;
      logic rise_now;
      assign partner_on = pr.cmpl & out_q[1-k];
      assign rise_now = pr.req[k] & ~out_q[k] & ~partner_on & (cnt_q[k] >= lim);

      // Output turns off at once, turns on only after the dead time
      always_ff @(posedge clk) begin
        if (rst || !pr.req[k] || partner_on) begin
          out_q[k] <= 1'b0;
          cnt_q[k] <= 8'h00;
        end else if (rise_now) begin
          out_q[k] <= 1'b1;
        end else if (!out_q[k]) begin
          cnt_q[k] <= cnt_q[k] + 8'h01;
        end
      end

      // Sense level taken in the last cycle of dead time
      always_ff @(posedge clk) begin
        if (rst) begin
          smp_q[k] <= 1'b0;
        end else if (rise_now) begin
          smp_q[k] <= pr.sense;
        end
      end
    end
  endgenerate

  assign pr.out = out_q;
  assign pr.smp = smp_q;
endmodule : pfo_pair_stage

/* File: test/pfo_far_model.sv */
`timescale 1ns/1ps
// Fault sensors and current-sense comparators on the inverter side
module pfo_far_model (
  input wire logic clk,
  input wire logic [3:0] trip,
  input wire logic [2:0] sense,
  output logic [3:0] fault_pins,
  output logic [2:0] sense_pins
);
  // Sensors settle after an edge, never in the sampling step
  initial begin
    fault_pins = 4'h0;
    sense_pins = 3'h0;
  end
  always @(posedge clk) begin
    fault_pins <= trip;
    sense_pins <= sense;
  end
endmodule : pfo_far_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
`include "pfo_defs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import pfo_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [3:0] trip = 4'h0;
  logic [3:0] fault_pins;
  logic [2:0] sense = 3'h0;
  logic [2:0] sense_pins;
  pfo_ch_t pwm_out, pwm_oe_n;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int rises[$];
  logic last0 = 1'h0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  pfo_far_model u_far (.clk(clk), .trip(trip), .sense(sense),
    .fault_pins(fault_pins), .sense_pins(sense_pins));

  pfo_top u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FAULT_IN(fault_pins),
    .SENSE_IN(sense_pins), .PWM_OUT(pwm_out), .PWM_OE_N(pwm_oe_n), .IRQ(irq));

  // Cycle stamps of rising output 1, for period checks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    last0 <= pwm_out[0];
    if (pwm_out[0] === 1'h1 && last0 === 1'h0) rises.push_back(cyc);
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  // One APB transfer; waits on PREADY instead of assuming zero wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk

  // Manual pattern, then settle past the dead time before looking
  task automatic ovr_chk(input logic [5:0] pat, input logic [5:0] e);
    wr(`PFO_ADDR_OVR, {25'h0, 1'h1, pat});
    cycles(30);
    `CHK(pwm_out, e)
  endtask : ovr_chk

  // Gap between the second and third rise avoids a partial first period
  task automatic period_chk(input int e);
    rises.delete();
    cycles(3 * e + 8);
    `CHK((rises.size() > 2 ? rises[2] - rises[1] : 0), e)
  endtask : period_chk

  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    cycles(4);
    rst <= 1'h0;
    rd_chk(`PFO_ADDR_FCR, 32'h0);
    rd_chk(`PFO_ADDR_OVR, 32'h0);
    rd_chk(`PFO_ADDR_FSR, 32'h0);
    rd_chk(`PFO_ADDR_MAP, 32'hff);
    `CHK(pwm_oe_n, 6'h3f)
    wr(`PFO_ADDR_MAP, 32'h01);
    wr(`PFO_ADDR_MAP, 32'hff);
    rd_chk(`PFO_ADDR_MAP, 32'h01);
    rd_chk(8'h40, 32'h0);
    `CHK(err, 1'h1)
    wr(`PFO_ADDR_FCR, 32'hff);
    rd_chk(`PFO_ADDR_FCR, 32'hff);
    wr(`PFO_ADDR_FCR, 32'h02);
    // Independent override drives pins even while disabled
    wr(`PFO_ADDR_CFG, 32'h02);
    ovr_chk(6'h3f, 6'h3f);
    `CHK(pwm_oe_n, 6'h00)
    // Fault 2, interrupt off, manual: only mapped output 1 drops
    trip <= 4'h2;
    cycles(6);
    `CHK(pwm_out, 6'h3e)
    `CHK(irq, 1'h0)
    rd_chk(`PFO_ADDR_FSR, 32'h0c);
    trip <= 4'h0;
    wr(`PFO_ADDR_ACK, 32'h0);
    rd_chk(`PFO_ADDR_FSR, 32'h04);
    `CHK(pwm_out, 6'h3e)
    wr(`PFO_ADDR_ACK, 32'h2);
    rd_chk(`PFO_ADDR_FSR, 32'h0);
    cycles(4);
    `CHK(pwm_out, 6'h3f)
    // Fault 1 with interrupt on; pin stays high through the ack
    trip <= 4'h1;
    cycles(5);
    `CHK(irq, 1'h1)
    wr(`PFO_ADDR_ACK, 32'h1);
    rd_chk(`PFO_ADDR_FSR, 32'h02);
    `CHK(irq, 1'h0)
    trip <= 4'h0;
    // Complementary pairing and current-sense capture
    // Sense 1 and 3 high: odd outputs of pairs 1 and 3 capture a one
    wr(`PFO_ADDR_CFG, 32'h00);
    sense <= 3'h5;
    ovr_chk(6'h15, 6'h15);
    sense <= 3'h0;
    ovr_chk(6'h2a, 6'h2a);
    apb(1'h0, `PFO_ADDR_ACK, 32'h0);
    `CHK(rd[9:0], 10'h110)
    ovr_chk(6'h3f, 6'h15);
    wr(`PFO_ADDR_OVR, 32'h0);
    cycles(3);
    `CHK(pwm_oe_n, 6'h3f)
    // Generator: periods, override while running, release
    wr(`PFO_ADDR_MOD, 32'h10);
    wr(`PFO_ADDR_DUTY, 32'h08);
    wr(`PFO_ADDR_CFG, 32'h03);
    period_chk(16);
    wr(`PFO_ADDR_OVR, 32'h40);
    cycles(25);
    `CHK(pwm_out, 6'h00)
    wr(`PFO_ADDR_OVR, 32'h0);
    period_chk(16);
    wr(`PFO_ADDR_CFG, 32'h02);
    wr(`PFO_ADDR_CFG, 32'h13);
    period_chk(32);
    // Code 01: modulus written in period 1 first shapes period 3
    wr(`PFO_ADDR_CFG, 32'h06);
    rises.delete();
    wr(`PFO_ADDR_CFG, 32'h07);
    wr(`PFO_ADDR_MOD, 32'h20);
    cycles(100);
    `CHK((rises.size() > 3 ? rises[2] - rises[1] : 0), 16)
    `CHK((rises.size() > 3 ? rises[3] - rises[2] : 0), 32)
    // Automatic fault 1 blocks output 1, then frees it with no acknowledge
    wr(`PFO_ADDR_FCR, 32'h01);
    trip <= 4'h1;
    cycles(8);
    `CHK(pwm_out[0], 1'h0)
    trip <= 4'h0;
    cycles(8);
    rises.delete();
    cycles(80);
    `CHK((rises.size() > 0), 1'h1)
    finish_test();
  end
endmodule : testbench
